// File: verilog/los_ctrl_consts.svh
`ifndef LOS_CTRL_CONSTS_SVH
`define LOS_CTRL_CONSTS_SVH

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008

// control register fields
`define CTRL_REF_LSB 0
`define CTRL_RATE_BIT 3
`define CTRL_RXEN_BIT 4
`define CTRL_EXLOSS_BIT 5
`define CTRL_EQ_LSB 6
`define CTRL_RESET 32'h0000_0010

// status and mask layout
`define ST_LOS_EVT_BIT 0
`define ST_LOS_NOW_BIT 1
`define ST_REF_OK_BIT 2
`define MASK_RESET 1'h0

// equalizer field bit that picks E1 over T1
`define EQ_E1_BIT 3

// reference select codes
`define REF_2048K 3'h0
`define REF_1544K 3'h1

// loss declaration thresholds in consecutive zeros
`define E1_LOS_ZEROS 13'h0020
`define E1_EXT_LOS_ZEROS 13'h1000
`define T1_LOS_ZEROS 13'h00AF

// loss clearing windows
`define E1_WIN_BITS 8'h20
`define E1_WIN_ONES 8'h04
`define E1_WIN_MAXRUN 13'h0010
`define T1_WIN_BITS 8'h80
`define T1_WIN_ONES 8'h10
`define T1_WIN_MAXRUN 13'h0064

// clock synthesis
`define SYS_CLK_HZ 100000000
`define E1_MCLK_KHZ 2048
`define T1_MCLK_KHZ 1544
`define NCO_INC(k) (32'(((64'(k) * 64'd1000) << 32) / 64'(`SYS_CLK_HZ)))
`define REF_TIMEOUT_NS 500000
`define REF_TIMEOUT_CYC (`REF_TIMEOUT_NS / (1000000000 / `SYS_CLK_HZ))

`endif

// File: verilog/los_ctrl_pkg.sv
`default_nettype none
package los_ctrl_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic {
        LOS_CLEAR,
        LOS_DECLARED
    } los_state_t;

    typedef struct packed {
        logic [2:0] sync_ref_e1;
        logic [2:0] sync_ref_t1;
        logic [2:0] sync_rclk;
        logic [1:0] sync_pos;
        logic [1:0] sync_neg;
        logic [1:0] sync_aloss;
        logic [1:0] sync_lvl;
        logic [31:0] ctrl;
        logic mask;
        logic los_evt;
        logic [31:0] nco;
        logic mclk;
        logic [31:0] ref_age;
        logic ref_ok;
        los_state_t los;
        logic [12:0] zero_run;
        logic [7:0] win_bits;
        logic [7:0] win_ones;
        logic win_bad;
        logic rx_pos;
        logic rx_neg;
    } ctrl_state_t;

endpackage
`default_nettype wire

// File: verilog/los_master_clock_ctrl.sv
// Added by the designer: the APB slave port and the register addresses.
`include "los_ctrl_consts.svh"
// Overview of operation
// [R1] synthesize 1544 or 2048 kHz master clock
// [R2] board ties single reference to both inputs
// [R3] three-bit code picks the reference rate
// [R4] rate bit: 0 gives 2048, 1 gives 1544
// [R5] host mode takes settings from registers
// [R6] equalizer field selects T1 or E1 thresholds
// [R7] pin mode: receiver always on
// [R8] host mode: receiver enable bit controls receiver
// [R9] recovered data passes to receive outputs
// [R10] clock recovery needs no external parts
// [R11] E1: loss after 32 zeros under analog loss
// [R12] E1 extended option: loss after 4096 zeros
// [R13] T1: loss after 175 zeros
// [R14] E1 clear: level up, 4 ones/32, run<=16
// [R15] T1 clear: level up, 16 ones/128, run<=100
// [R16] loss sets status; enabled interrupt drives low
// [R17] status read clears alarm, releases interrupt
// [R18] zero counter restarts on ones, counts under loss
// [R19] clear checked on non-overlapping windows
`timescale 1ns/1ps
`default_nettype none

module los_master_clock_ctrl
    import los_ctrl_pkg::*;
#(
    parameter int REF_TIMEOUT = `REF_TIMEOUT_CYC
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // apb slave
    input wire apb_req_t i_apb,
    output apb_rsp_t o_apb,
    // mode and configuration pins
    input wire logic i_host_mode,
    input wire logic [2:0] i_ref_rate_select,
    input wire logic i_master_rate_select,
    input wire logic [4:0] i_equalizer_control_field,
    input wire logic i_extended_loss_option,
    // reference clocks
    input wire logic i_e1_ref_clock_in,
    input wire logic i_t1_ref_clock_in,
    // recovered line data
    input wire logic i_rx_clk,
    input wire logic i_rx_pos,
    input wire logic i_rx_neg,
    input wire logic i_analog_loss,
    input wire logic i_level_restored,
    // outputs
    output logic o_master_clk,
    output logic o_ref_active,
    output logic o_receive_positive_data_out,
    output logic o_receive_negative_or_violation_out,
    output logic o_receive_signal_loss,
    output logic o_int_n
);

    ctrl_state_t s_q;
    ctrl_state_t s_d;

    logic [2:0] ref_sel;
    logic rate_t1;
    logic [4:0] eq_field;
    logic ext_loss;
    logic rx_on;
    logic e1_mode;
    logic ref_edge;
    logic rx_edge;
    logic bit_one;
    logic [12:0] los_limit;
    logic [7:0] win_len;
    logic [7:0] win_need;
    logic [12:0] run_max;
    logic [12:0] run_next;
    logic acc_phase;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_status;
    logic mapped;
    logic win_end;
    logic win_pass;

    // host mode reads the register copy; pin mode the pins
    always_comb begin
        if (i_host_mode) begin
            ref_sel = s_q.ctrl[`CTRL_REF_LSB +: 3]; // [R5]
            rate_t1 = s_q.ctrl[`CTRL_RATE_BIT]; // [R5]
            eq_field = s_q.ctrl[`CTRL_EQ_LSB +: 5];
            ext_loss = s_q.ctrl[`CTRL_EXLOSS_BIT];
            rx_on = s_q.ctrl[`CTRL_RXEN_BIT]; // [R8]
        end else begin
            ref_sel = i_ref_rate_select;
            rate_t1 = i_master_rate_select;
            eq_field = i_equalizer_control_field;
            ext_loss = i_extended_loss_option;
            rx_on = 1'b1; // [R7]
        end
    end

    assign e1_mode = eq_field[`EQ_E1_BIT]; // [R6]

    // every code but the 1544 kHz one uses the E1 input; a board with one
    // source must tie it to both inputs for codes 0 and 1
    always_comb begin
        unique case (ref_sel) // [R3] [R2]
            `REF_1544K: ref_edge = s_q.sync_ref_t1[1] & ~s_q.sync_ref_t1[2];
            default: ref_edge = s_q.sync_ref_e1[1] & ~s_q.sync_ref_e1[2];
        endcase
    end

    assign rx_edge = s_q.sync_rclk[1] & ~s_q.sync_rclk[2];
    assign bit_one = s_q.sync_pos[1] | s_q.sync_neg[1];

    always_comb begin
        if (e1_mode) begin
            los_limit = ext_loss ? `E1_EXT_LOS_ZEROS : `E1_LOS_ZEROS; // [R11] [R12]
            win_len = `E1_WIN_BITS; // [R14]
            win_need = `E1_WIN_ONES;
            run_max = `E1_WIN_MAXRUN;
        end else begin
            los_limit = `T1_LOS_ZEROS; // [R13]
            win_len = `T1_WIN_BITS; // [R15]
            win_need = `T1_WIN_ONES;
            run_max = `T1_WIN_MAXRUN;
        end
    end

    // saturating run of zeros, restarted by any one
    assign run_next = bit_one ? 13'h0 :
        ((&s_q.zero_run) ? s_q.zero_run : s_q.zero_run + 13'h1); // [R18]

    assign win_end = rx_edge && (s_q.win_bits == win_len - 8'h1);
    assign win_pass = (s_q.win_ones + {7'h0, bit_one} >= win_need)
        && !s_q.win_bad && (run_next <= run_max)
        && s_q.sync_lvl[1]; // [R14] [R15]

    // apb decode
    assign acc_phase = i_apb.psel & i_apb.penable;
    assign mapped = (i_apb.paddr == `OFS_CTRL) || (i_apb.paddr == `OFS_STATUS)
        || (i_apb.paddr == `OFS_MASK);
    assign wr_ctrl = acc_phase & i_apb.pwrite & (i_apb.paddr == `OFS_CTRL);
    assign wr_mask = acc_phase & i_apb.pwrite & (i_apb.paddr == `OFS_MASK);
    assign rd_status = acc_phase & ~i_apb.pwrite & (i_apb.paddr == `OFS_STATUS);

    always_comb begin
        o_apb.pready = 1'b1;
        o_apb.pslverr = acc_phase & ~mapped;
        o_apb.prdata = 32'h0;
        if (acc_phase && !i_apb.pwrite) begin
            unique case (i_apb.paddr)
                `OFS_CTRL: o_apb.prdata = s_q.ctrl;
                `OFS_STATUS: begin
                    o_apb.prdata[`ST_LOS_EVT_BIT] = s_q.los_evt;
                    o_apb.prdata[`ST_LOS_NOW_BIT] = (s_q.los == LOS_DECLARED);
                    o_apb.prdata[`ST_REF_OK_BIT] = s_q.ref_ok;
                end
                `OFS_MASK: o_apb.prdata[0] = s_q.mask;
                default: o_apb.prdata = 32'h0;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.sync_ref_e1 = {s_q.sync_ref_e1[1:0], i_e1_ref_clock_in};
        s_d.sync_ref_t1 = {s_q.sync_ref_t1[1:0], i_t1_ref_clock_in};
        s_d.sync_rclk = {s_q.sync_rclk[1:0], i_rx_clk};
        s_d.sync_pos = {s_q.sync_pos[0], i_rx_pos};
        s_d.sync_neg = {s_q.sync_neg[0], i_rx_neg};
        s_d.sync_aloss = {s_q.sync_aloss[0], i_analog_loss};
        s_d.sync_lvl = {s_q.sync_lvl[0], i_level_restored};

        if (wr_ctrl) begin
            s_d.ctrl = i_apb.pwdata;
        end
        if (wr_mask) begin
            s_d.mask = i_apb.pwdata[0];
        end

        // master clock from a phase accumulator; edges jitter by one
        // system clock, which the analog pulse shaper tolerates
        s_d.nco = s_q.nco + (rate_t1 ? `NCO_INC(`T1_MCLK_KHZ)
            : `NCO_INC(`E1_MCLK_KHZ)); // [R1] [R4]
        s_d.mclk = s_q.nco[31];

        // reference watchdog
        if (ref_edge) begin
            s_d.ref_age = 32'h0;
            s_d.ref_ok = 1'b1;
        end else if (s_q.ref_age >= 32'(REF_TIMEOUT)) begin
            s_d.ref_ok = 1'b0;
        end else begin
            s_d.ref_age = s_q.ref_age + 32'h1;
        end

        // data path; a disabled receiver holds its outputs low
        if (!rx_on) begin
            s_d.rx_pos = 1'b0;
            s_d.rx_neg = 1'b0;
        end else if (rx_edge) begin
            s_d.rx_pos = s_q.sync_pos[1]; // [R9] [R10]
            s_d.rx_neg = s_q.sync_neg[1];
        end

        // loss detector
        if (!rx_on) begin
            s_d.los = LOS_CLEAR;
            s_d.zero_run = 13'h0;
            s_d.win_bits = 8'h0;
            s_d.win_ones = 8'h0;
            s_d.win_bad = 1'b0;
        end else if (rx_edge) begin
            unique case (s_q.los)
                LOS_CLEAR: begin
                    s_d.zero_run = s_q.sync_aloss[1] ? run_next : 13'h0; // [R18]
                    if (s_q.sync_aloss[1] && run_next >= los_limit) begin
                        s_d.los = LOS_DECLARED; // [R11] [R12] [R13]
                        s_d.zero_run = 13'h0;
                        s_d.win_bits = 8'h0;
                        s_d.win_ones = 8'h0;
                        s_d.win_bad = 1'b0;
                    end
                end
                LOS_DECLARED: begin
                    s_d.zero_run = run_next;
                    if (win_end) begin
                        s_d.win_bits = 8'h0; // [R19]
                        s_d.win_ones = 8'h0;
                        s_d.win_bad = 1'b0;
                        if (win_pass) begin
                            s_d.los = LOS_CLEAR; // [R14] [R15] [R19]
                            s_d.zero_run = 13'h0;
                        end
                    end else begin
                        s_d.win_bits = s_q.win_bits + 8'h1;
                        s_d.win_ones = s_q.win_ones + {7'h0, bit_one};
                        if (run_next > run_max || !s_q.sync_lvl[1]) begin
                            s_d.win_bad = 1'b1;
                        end
                    end
                end
            endcase
        end

        // sticky alarm: a read clears it, a new declaration wins
        if (rd_status) begin
            s_d.los_evt = 1'b0; // [R17]
        end
        if (s_q.los == LOS_CLEAR && s_d.los == LOS_DECLARED) begin
            s_d.los_evt = 1'b1; // [R16]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.ctrl <= `CTRL_RESET;
            s_q.mask <= `MASK_RESET;
            s_q.los <= LOS_CLEAR;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_master_clk = s_q.mclk;
    assign o_ref_active = s_q.ref_ok;
    assign o_receive_positive_data_out = s_q.rx_pos;
    assign o_receive_negative_or_violation_out = s_q.rx_neg;
    assign o_receive_signal_loss = (s_q.los == LOS_DECLARED); // [R16]
    assign o_int_n = ~(s_q.los_evt & s_q.mask); // [R16] [R17]

endmodule

`default_nettype wire

// File: verif/los_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "los_ctrl_consts.svh"
module los_ctrl_properties
    import los_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register bus
    input wire apb_req_t i_apb,
    input wire apb_rsp_t o_apb,
    // line status and outputs
    input wire logic i_analog_loss,
    input wire logic i_level_restored,
    input wire logic o_master_clk,
    input wire logic o_receive_positive_data_out,
    input wire logic o_receive_signal_loss,
    input wire logic o_int_n
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic acc, rd_st, bad, mask_q;
    assign acc = i_apb.psel && i_apb.penable;
    assign rd_st = acc && i_ce && !i_apb.pwrite && i_apb.paddr == `OFS_STATUS;
    assign bad = !(i_apb.paddr inside {`OFS_CTRL, `OFS_STATUS, `OFS_MASK});
    // interrupt enable mirrored from bus writes, since the register is not a port
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mask_q <= 1'b0;
        end else if (acc && i_ce && i_apb.pwrite && i_apb.paddr == `OFS_MASK) begin
            mask_q <= i_apb.pwdata[0];
        end
    end
    AST_IDLE_BUS: assert property (!acc |-> o_apb.prdata == 32'h0 && !o_apb.pslverr)
        else $error("bus answer outside access");
    AST_UNMAPPED: assert property (acc && bad |-> o_apb.pslverr && o_apb.prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (acc && !bad |-> o_apb.pready && !o_apb.pslverr)
        else $error("mapped access refused");
    AST_LOS_NOW: assert property (
        rd_st |-> o_apb.prdata[`ST_LOS_NOW_BIT] == o_receive_signal_loss)
        else $error("status loss bit differs from output");
    AST_INT_LOS: assert property ($rose(o_receive_signal_loss) && mask_q |-> !o_int_n)
        else $error("enabled loss gave no interrupt");
    AST_INT_REL: assert property (rd_st |=> o_int_n || $rose(o_receive_signal_loss))
        else $error("status read left interrupt low");
    // two sync flops plus the output register: the pin was sampled three edges back
    AST_LOS_CAUSE: assert property ($rose(o_receive_signal_loss) |-> $past(i_analog_loss, 3))
        else $error("loss declared without analog loss");
    AST_CLR_CAUSE: assert property ($fell(o_receive_signal_loss) |-> $past(i_level_restored, 3))
        else $error("loss cleared without level");
    AST_MCLK_HALF: assert property (
        $rose(o_master_clk) |=> o_master_clk [*8] ##[11:27] !o_master_clk)
        else $error("master clock half period off");
    AST_RST_OUT: assert property (@(posedge i_clk) disable iff (1'b0)
        !i_rst_n |=> o_int_n && !o_receive_signal_loss && !o_master_clk && !o_receive_positive_data_out)
        else $error("outputs not idle after reset");
endmodule
bind los_master_clock_ctrl los_ctrl_properties los_ctrl_properties_i (
    .i_clk, .i_rst_n, .i_ce, .i_apb, .o_apb, .i_analog_loss, .i_level_restored,
    .o_master_clk, .o_receive_positive_data_out, .o_receive_signal_loss, .o_int_n
);
`default_nettype wire

// File: verif/line_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote transmitter: one ami bit per 8 clocks, bit clock halts between bursts
module line_tx_model (
    // control
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic i_one,
    // line
    output logic o_rx_clk,
    output logic o_pos,
    output logic o_neg,
    output logic o_tick
);
    logic [2:0] ph = 3'h0;
    logic mark = 1'b0;
    logic t = 1'b0;
    always_ff @(posedge i_clk) begin
        o_tick <= 1'b0;
        t <= ~t;
        if (ph == 3'h0 && !i_en) begin
            // idle rails wander so a stale bit never looks valid
            o_rx_clk <= 1'b0;
            o_pos <= t;
            o_neg <= ~t;
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h0) begin
                o_rx_clk <= 1'b1;
                o_tick <= 1'b1;
                o_pos <= i_one && !mark;
                o_neg <= i_one && mark;
                mark <= mark ^ i_one;
            end
            if (ph == 3'h4) begin
                o_rx_clk <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/los_master_clock_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "los_ctrl_consts.svh"
module los_master_clock_ctrl_tb;
    import los_ctrl_pkg::*;
    logic clk, rst_n, ce, host, rate, ext, e1, one_src, aloss, lvl, en, one, e;
    logic mclk, refa, pos, neg, los, int_n, rxc, rp, rn, tick;
    logic [2:0] rsel;
    logic [4:0] eq;
    logic [31:0] seed, r;
    apb_req_t req;
    apb_rsp_t rsp;
    int mismatches, checked, cyc;
    los_master_clock_ctrl #(.REF_TIMEOUT(200)) los_master_clock_ctrl_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_apb(req), .o_apb(rsp),
        .i_host_mode(host), .i_ref_rate_select(rsel), .i_master_rate_select(rate),
        .i_equalizer_control_field(eq), .i_extended_loss_option(ext),
        .i_e1_ref_clock_in(e1), .i_t1_ref_clock_in(e1 && one_src), .i_rx_clk(rxc),
        .i_rx_pos(rp), .i_rx_neg(rn), .i_analog_loss(aloss), .i_level_restored(lvl),
        .o_master_clk(mclk), .o_ref_active(refa), .o_receive_positive_data_out(pos),
        .o_receive_negative_or_violation_out(neg), .o_receive_signal_loss(los),
        .o_int_n(int_n));
    line_tx_model line_tx_model_i (.i_clk(clk), .i_en(en), .i_one(one), .o_rx_clk(rxc),
        .o_pos(rp), .o_neg(rn), .o_tick(tick));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task final_report();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // bit i is a one when per divides i and i is below lim
    task send(input int n, input int per, input int lim);
        for (int i = 0; i < n; i++) begin
            en <= 1'b1;
            one <= per != 0 && i % per == 0 && i < lim;
            do @(posedge clk); while (tick !== 1'b1);
        end
        en <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    // a leading one restarts the zero run so the count is exact
    task lose(input int n);
        send(1, 1, 1);
        send(n - 1, 0, 0);
        chk(32'(los), 32'h0);
        send(1, 0, 0);
        chk(32'(los), 32'h1);
    endtask
    task mper(input int khz);
        int n, k;
        logic p;
        n = 0;
        k = 0;
        p = 1'b1;
        while (k < 9) begin
            @(posedge clk);
            if (mclk === 1'b1 && !p) k++;
            if (k > 0) n++;
            p = mclk;
        end
        chk(32'(n >= 800000 / khz - 2 && n <= 800000 / khz + 3), 32'h1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 20 == 0) e1 <= ~e1;
        if (cyc == 90000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rst_n, rate, ext, e1, one_src, aloss, lvl, en, one, rsel, eq} = '0;
        host = 1'b1;
        ce = 1'b1;
        req = '0;
        seed = 32'h5A35FAE7;
        {mismatches, checked, cyc} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(r, `CTRL_RESET);
        apb(1'b0, `OFS_MASK, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, `OFS_CTRL, xs());
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(r, seed);
        for (int c = 0; c < 8; c++) begin
            void'(xs());
            apb(1'b1, `OFS_CTRL, 32'h10 | (32'(seed[0]) << 3) | 32'(c));
            mper(seed[0] ? 1544 : 2048);
            chk(32'(refa), 32'(c != 1));
        end
        one_src <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'h11);
        repeat (300) @(posedge clk);
        chk(32'(refa), 32'h1);
        host <= 1'b0;
        rate <= 1'b1;
        mper(1544);
        rate <= 1'b0;
        mper(2048);
        host <= 1'b1;
        aloss <= 1'b1;
        apb(1'b1, `OFS_MASK, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h210);
        lose(32);
        chk(32'(int_n), 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r & 32'h3, 32'h3);
        @(posedge clk);
        chk(32'(int_n), 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r & 32'h3, 32'h2);
        lvl <= 1'b1;
        send(32, 8, 17);
        chk(32'(los), 32'h1);
        send(32, 8, 32);
        chk(32'(los), 32'h0);
        lvl <= 1'b0;
        send(31, 0, 0);
        send(1, 1, 1);
        send(31, 0, 0);
        chk(32'(los), 32'h0);
        aloss <= 1'b0;
        send(40, 0, 0);
        chk(32'(los), 32'h0);
        aloss <= 1'b1;
        apb(1'b1, `OFS_CTRL, 32'h10);
        lose(175);
        lvl <= 1'b1;
        send(128, 8, 128);
        chk(32'(los), 32'h0);
        lvl <= 1'b0;
        host <= 1'b0;
        eq <= 5'h08;
        ext <= 1'b1;
        lose(4096);
        lvl <= 1'b1;
        send(32, 8, 32);
        chk(32'(los), 32'h0);
        host <= 1'b1;
        lvl <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h200);
        send(40, 1, 40);
        chk(32'({pos, neg}), 32'h0);
        send(40, 0, 0);
        chk(32'(los), 32'h0);
        aloss <= 1'b0;
        apb(1'b1, `OFS_CTRL, 32'h210);
        repeat (24) begin
            void'(xs());
            send(1, 32'(seed[0]), 1);
            chk(32'({pos | neg, pos & neg}), 32'({seed[0], 1'b0}));
        end
        // a write with the clock enable low must not land
        ce <= 1'b0;
        apb(1'b1, `OFS_MASK, 32'h0);
        ce <= 1'b1;
        apb(1'b0, `OFS_MASK, 32'h0);
        chk(r, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
